// >>> hw/chdiv_pkg.sv
// constants for the two differential channel dividers
// assumes 8-bit registers reached over a 32-bit classic wishbone slave
package chdiv_pkg;
  localparam int ADDR_W = 12;
  localparam logic [7:0] FIRST_COUNTS_IDX = 8'h90;
  localparam logic [11:0] FIRST_CYCLE_COUNTS = 12'h190;
  localparam logic [11:0] FIRST_CONTROL = 12'h191;
  localparam logic [11:0] FIRST_ROUTE_DUTY = 12'h192;
  localparam logic [11:0] SECOND_CYCLE_COUNTS = 12'h196;
  localparam logic [11:0] SECOND_CONTROL = 12'h197;
  localparam logic [11:0] SECOND_ROUTE_DUTY = 12'h198;
  localparam logic [11:0] REG_BASE = 12'h000;
  // control and route-duty register fields and reset values
  localparam int BYPASS_BIT = 7;
  localparam int NOSYNC_BIT = 6;
  localparam int FORCE_BIT = 5;
  localparam int START_BIT = 4;
  localparam int ROUTE_BIT = 1;
  localparam int DCC_OFF_BIT = 0;
  localparam logic [7:0] COUNTS_RESET = 8'h00;
  localparam logic [7:0] FIRST_CONTROL_RESET = 8'h80;
  localparam logic [7:0] SECOND_CONTROL_RESET = 8'h00;
  localparam logic [7:0] ROUTE_DUTY_RESET = 8'h00;
  localparam logic [7:0] ROUTE_DUTY_MASK = 8'h03;
  // distribution source select codes
  localparam logic [1:0] SRC_EXT_CLK = 2'h0;
  localparam logic [1:0] SRC_DIVIDED = 2'h1;
  localparam logic [1:0] SRC_VCO = 2'h2;
endpackage

// >>> hw/channel_dividers.sv
// two differential channel dividers with wishbone register slave
// assumes the high-speed inputs are sampled as enables of SYS_CLK
// Functional notes
// - output stays low for low-count plus one input cycles.
// - output stays high for high-count plus one input cycles.
// - bypass stops the counters and passes the input clock through.
// - first divider's bypass bit resets to one.
// - second divider's bypass bit resets to zero.
// - a clear ignore-sync bit obeys the sync request, a set bit ignores it.
// - force level acts only with ignore-sync set, one high, zero low.
// - the waveform begins at the level chosen by the start-level bit.
// - each divider has a four-bit phase offset resetting to zero.
// - direct-route bit zero feeds both pair outputs from the divider.
// - direct route with source select 10b sends the VCO clock to the pair.
// - direct route with source select 00b sends the external clock to the pair.
// - source select 01b ignores the direct-route bit.
// - second pair's direct route decodes the same source select.
// - duty correction is on while its disable bit is zero.
`timescale 1ns/100ps
`default_nettype none
module channel_dividers
  import chdiv_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [chdiv_pkg::ADDR_W-1:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [3:0] WB_SEL_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic SYNC_REQ,
  input wire logic [1:0] DIST_SOURCE_SELECT,
  input wire logic VCO_CLK,
  input wire logic EXT_CLK,
  output logic PAIR_A_OUTPUT_FIRST,
  output logic PAIR_A_OUTPUT_SECOND,
  output logic PAIR_B_OUTPUT_FIRST,
  output logic PAIR_B_OUTPUT_SECOND,
  output logic [1:0] DUTY_CORRECTION_ON
);
  import chdiv_pkg::*;

  logic [7:0] counts [2];
  logic [7:0] control [2];
  logic [7:0] route_duty [2];
  logic [3:0] count [2];
  logic [3:0] phase_wait [2];
  logic [1:0] level;
  logic [1:0] waiting;
  logic [1:0] div_in;
  logic [1:0] div_in_q;
  logic [1:0] div_out;
  logic [1:0] route_out;
  logic [1:0] pair_src;
  logic req;
  logic wr_lane0;
  logic [11:0] word_addr;
  logic [7:0] rd_byte;

  // register index from byte offset, -1 when unmapped
  function automatic int reg_index(input logic [11:0] a, output logic [1:0] kind);
    reg_index = -1;
    kind = 2'h3;
    case (a)
      FIRST_CYCLE_COUNTS:
      begin
        reg_index = 0;
        kind = 2'h0;
      end
      FIRST_CONTROL:
      begin
        reg_index = 0;
        kind = 2'h1;
      end
      FIRST_ROUTE_DUTY:
      begin
        reg_index = 0;
        kind = 2'h2;
      end
      SECOND_CYCLE_COUNTS:
      begin
        reg_index = 1;
        kind = 2'h0;
      end
      SECOND_CONTROL:
      begin
        reg_index = 1;
        kind = 2'h1;
      end
      SECOND_ROUTE_DUTY:
      begin
        reg_index = 1;
        kind = 2'h2;
      end
      default: reg_index = -1;
    endcase
  endfunction

  // source choice for one pair from its direct-route bit
  function automatic logic pick_route(input logic direct, input logic divided);
    pick_route = divided;
    if (direct)
    begin
      case (DIST_SOURCE_SELECT)
        SRC_VCO: pick_route = VCO_CLK;
        SRC_EXT_CLK: pick_route = EXT_CLK;
        default: pick_route = divided;
      endcase
    end
  endfunction

  assign req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  // registers sit at their own byte addresses
  assign word_addr = WB_ADR_I;
  assign wr_lane0 = req && WB_WE_I && WB_SEL_I[0];

  // wishbone ack one cycle after request
  always_ff @(posedge SYS_CLK)
  begin
    if (!RSTN)
      WB_ACK_O <= 1'b0;
    else
      WB_ACK_O <= req;
  end

  // register writes, byte lane 0 only
  always_ff @(posedge SYS_CLK)
  begin
    int idx;
    logic [1:0] kind;
    if (!RSTN)
    begin
      counts[0] <= COUNTS_RESET;
      counts[1] <= COUNTS_RESET;
      control[0] <= FIRST_CONTROL_RESET;
      control[1] <= SECOND_CONTROL_RESET;
      route_duty[0] <= ROUTE_DUTY_RESET;
      route_duty[1] <= ROUTE_DUTY_RESET;
    end
    else if (wr_lane0)
    begin
      idx = reg_index(word_addr, kind);
      if (idx >= 0)
      begin
        case (kind)
          2'h0: counts[idx[0]] <= WB_DAT_I[7:0];
          2'h1: control[idx[0]] <= WB_DAT_I[7:0];
          2'h2: route_duty[idx[0]] <= WB_DAT_I[7:0] & ROUTE_DUTY_MASK;
          default: ;
        endcase
      end
    end
  end

  // read data, unmapped reads zero
  always_ff @(posedge SYS_CLK)
  begin
    int idx;
    logic [1:0] kind;
    if (!RSTN)
      WB_DAT_O <= 32'h0000_0000;
    else if (req)
    begin
      idx = reg_index(word_addr, kind);
      WB_DAT_O <= 32'h0000_0000;
      if (idx >= 0)
      begin
        case (kind)
          2'h0: WB_DAT_O <= {24'h00_0000, counts[idx[0]]};
          2'h1: WB_DAT_O <= {24'h00_0000, control[idx[0]]};
          2'h2: WB_DAT_O <= {24'h00_0000, route_duty[idx[0]]};
          default: WB_DAT_O <= 32'h0000_0000;
        endcase
      end
    end
  end

  // each divider input is the chosen high-speed clock
  assign div_in[0] = (DIST_SOURCE_SELECT == SRC_EXT_CLK) ? EXT_CLK : VCO_CLK;
  assign div_in[1] = div_in[0];

  always_ff @(posedge SYS_CLK)
  begin
    if (!RSTN)
      div_in_q <= 2'h0;
    else
      div_in_q <= div_in;
  end

  // divider counters, one per channel
  for (genvar i = 0; i < 2; i++)
  begin : g_div
    logic tick;
    logic sync_hit;
    assign tick = div_in[i] && !div_in_q[i];
    // sync obeyed only with ignore bit clear
    assign sync_hit = SYNC_REQ && !control[i][NOSYNC_BIT];

    always_ff @(posedge SYS_CLK)
    begin
      if (!RSTN)
      begin
        level[i] <= 1'b0;
        count[i] <= 4'h0;
        phase_wait[i] <= 4'h0;
        waiting[i] <= 1'b1;
      end
      else if (control[i][BYPASS_BIT])
      begin
        count[i] <= 4'h0;
        waiting[i] <= 1'b1;
        phase_wait[i] <= control[i][3:0];
        level[i] <= control[i][START_BIT];
      end
      else if (sync_hit)
      begin
        level[i] <= control[i][START_BIT];
        count[i] <= 4'h0;
        phase_wait[i] <= control[i][3:0];
        waiting[i] <= 1'b1;
      end
      else if (tick)
      begin
        if (waiting[i])
        begin
          if (phase_wait[i] == 4'h0)
          begin
            waiting[i] <= 1'b0;
            level[i] <= control[i][START_BIT];
          end
          else
            phase_wait[i] <= phase_wait[i] - 4'h1;
        end
        // low then high counts plus one
        else if (count[i] == (level[i] ? counts[i][3:0] : counts[i][7:4]))
        begin
          count[i] <= 4'h0;
          level[i] <= !level[i];
        end
        else
          count[i] <= count[i] + 4'h1;
      end
    end

    always_comb
    begin
      if (control[i][NOSYNC_BIT] && !control[i][BYPASS_BIT] && waiting[i])
        div_out[i] = control[i][FORCE_BIT];
      else if (control[i][BYPASS_BIT])
        div_out[i] = div_in[i];
      else if (waiting[i])
        div_out[i] = control[i][START_BIT];
      else
        div_out[i] = level[i];
    end

    assign pair_src[i] = pick_route(route_duty[i][ROUTE_BIT], div_out[i]);
  end

  // outputs registered
  always_ff @(posedge SYS_CLK)
  begin
    if (!RSTN)
      route_out <= 2'h0;
    else
      route_out <= pair_src;
  end

  assign PAIR_A_OUTPUT_FIRST = route_out[0];
  assign PAIR_A_OUTPUT_SECOND = route_out[0];
  assign PAIR_B_OUTPUT_FIRST = route_out[1];
  assign PAIR_B_OUTPUT_SECOND = route_out[1];

  // correction on while disable bit zero
  always_ff @(posedge SYS_CLK)
  begin
    if (!RSTN)
      DUTY_CORRECTION_ON <= 2'h3;
    else
      DUTY_CORRECTION_ON <= {!route_duty[1][DCC_OFF_BIT], !route_duty[0][DCC_OFF_BIT]};
  end
endmodule // channel_dividers
`default_nettype wire

// >>> sim/chdiv_monitor.sv
// port checker for channel_dividers
// assumes a bind from the bench top file
`timescale 1ns/100ps
`default_nettype none
module chdiv_monitor
(
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  input wire logic PAIR_A_OUTPUT_FIRST,
  input wire logic PAIR_A_OUTPUT_SECOND,
  input wire logic PAIR_B_OUTPUT_FIRST,
  input wire logic PAIR_B_OUTPUT_SECOND,
  input wire logic [1:0] DUTY_CORRECTION_ON
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);
  a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  a_ack_answer: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("request not answered next cycle");
  a_ack_cause: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
    else $error("ack without request");
  a_idle_quiet: assert property (!WB_STB_I [*2] |=> !WB_ACK_O)
    else $error("ack while idle");
  a_rdata_upper: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_pair_a_same: assert property (PAIR_A_OUTPUT_FIRST == PAIR_A_OUTPUT_SECOND)
    else $error("pair a outputs differ");
  a_pair_b_same: assert property (PAIR_B_OUTPUT_FIRST == PAIR_B_OUTPUT_SECOND)
    else $error("pair b outputs differ");
  a_duty_bus: assert property (!$stable(DUTY_CORRECTION_ON) |->
    $past(WB_CYC_I) || $past(WB_CYC_I, 2) || $past(WB_CYC_I, 3))
    else $error("duty status changed without access");
endmodule // chdiv_monitor
`default_nettype wire

// >>> sim/differential_channel_dividers_test.sv
// self-checking bench for channel_dividers
// assumes chdiv_pkg and the design compiled first
`timescale 1ns/100ps
`default_nettype none
module differential_channel_dividers_test;
  import chdiv_pkg::*;
  logic clk = 0, rstn = 0, cyc = 0, stb = 0, we = 0, vco = 0, ext = 0, ack;
  logic sreq = 0;
  logic [11:0] adr = 12'h0;
  logic [31:0] wdat = 32'h0, rdat;
  logic [1:0] src = 2'h1, duty, ec = 2'h0;
  logic [3:0] po;
  int n_mismatch = 0, samples_checked = 0;
  always #20 clk = ~clk;
  always @(posedge clk) vco <= ~vco;
  always @(posedge clk) ec <= (ec == 2'h2) ? 2'h0 : ec + 2'h1;
  always @(posedge clk) ext <= (ec == 2'h2) ? ~ext : ext;
  channel_dividers dut_u (.SYS_CLK(clk), .RSTN(rstn), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_SEL_I(4'hF), .WB_DAT_O(rdat),
    .WB_ACK_O(ack), .SYNC_REQ(sreq), .DIST_SOURCE_SELECT(src), .VCO_CLK(vco),
    .EXT_CLK(ext), .PAIR_A_OUTPUT_FIRST(po[0]), .PAIR_A_OUTPUT_SECOND(po[1]),
    .PAIR_B_OUTPUT_FIRST(po[2]), .PAIR_B_OUTPUT_SECOND(po[3]), .DUTY_CORRECTION_ON(duty));
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude();
    if (n_mismatch == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // one classic cycle, held until ack
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d,
    output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    check("rdata", q, {24'h0, e});
  endtask
  // high and low run lengths in system cycles
  task automatic runs(input int i, input int hi, input int lo);
    int h, l;
    repeat (40) @(posedge clk);
    while (po[i] !== 1'b0) @(posedge clk);
    while (po[i] !== 1'b1) @(posedge clk);
    for (h = 0; po[i] === 1'b1; h++) @(posedge clk);
    for (l = 0; po[i] === 1'b0; l++) @(posedge clk);
    check("high run", h, hi);
    check("low run", l, lo);
  endtask
  task automatic t_reset();
    rd(FIRST_CYCLE_COUNTS, 8'h00);
    rd(FIRST_CONTROL, 8'h80);
    rd(SECOND_CONTROL, 8'h00);
    rd(SECOND_ROUTE_DUTY, 8'h00);
    rd(12'h193, 8'h00);
    check("duty", duty, 2'h3);
    runs(0, 1, 1);
  endtask
  task automatic t_divide();
    wr(SECOND_CYCLE_COUNTS, 8'h12);
    wr(SECOND_ROUTE_DUTY, 8'h02);
    rd(SECOND_ROUTE_DUTY, 8'h02);
    runs(2, 6, 4);
    src <= SRC_VCO;
    runs(3, 1, 1);
    src <= SRC_EXT_CLK;
    runs(2, 3, 3);
    wr(SECOND_ROUTE_DUTY, 8'h00);
    runs(2, 18, 12);
  endtask
  // sync pulse then settled output level
  task automatic t_sync();
    logic [15:0] cfg = 16'h1303;
    for (int k = 0; k < 2; k++)
    begin
      wr(SECOND_CONTROL, cfg[15-8*k -: 8]);
      @(posedge clk);
      sreq <= 1'b1;
      repeat (2) @(posedge clk);
      sreq <= 1'b0;
      repeat (3) @(posedge clk);
      check("sync level", po[2], k == 0);
    end
    wr(SECOND_CONTROL, 8'h40);
    @(posedge clk);
    sreq <= 1'b1;
    runs(2, 18, 12);
    sreq <= 1'b0;
  endtask
  task automatic t_levels();
    logic [23:0] cfg = 24'h6F4F1F;
    for (int k = 0; k < 3; k++)
    begin
      wr(FIRST_CONTROL, 8'h80);
      wr(FIRST_CONTROL, cfg[23-8*k -: 8]);
      repeat (3) @(posedge clk);
      check("held level", po[0], k != 1);
    end
    rd(FIRST_CONTROL, 8'h1F);
  endtask
  task automatic t_duty();
    wr(FIRST_ROUTE_DUTY, 8'hFF);
    rd(FIRST_ROUTE_DUTY, 8'h03);
    repeat (4) @(posedge clk);
    check("duty off", duty, 2'h2);
    wr(FIRST_ROUTE_DUTY, 8'h00);
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_divide();
    t_levels();
    t_sync();
    t_duty();
    conclude();
  end
  initial
  begin
    #200000;
    n_mismatch++;
    conclude();
  end
endmodule // differential_channel_dividers_test
bind channel_dividers chdiv_monitor mon_u (.SYS_CLK, .RSTN, .WB_CYC_I, .WB_STB_I,
  .WB_DAT_O, .WB_ACK_O, .PAIR_A_OUTPUT_FIRST, .PAIR_A_OUTPUT_SECOND,
  .PAIR_B_OUTPUT_FIRST, .PAIR_B_OUTPUT_SECOND, .DUTY_CORRECTION_ON);
`default_nettype wire
